// [dv/sfif_framer_chk.sv]
// Checker for the framer's ports, bound into every framer instance.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/100ps
module sfif_framer_chk import sfif_pkg::*; (
  input wire logic clk,
  input wire logic rst,
  input wire logic csN,
  input wire logic [3:0] ioOe,
  input wire sfif_cmd_type cmdPulse,
  input wire logic [7:0] readParameterByte,
  input wire logic [2:0] wrapSettingBits,
  input wire logic progValid,
  input wire logic progReady,
  input wire sfif_prog_type progWord,
  input wire logic progOverrun
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ----
  // Properties
  // ----
  sequence csIdle;
    csN [*4];
  endsequence
  oe_release_a: assert property (csIdle ##1 csN [*2] |-> ioOe == 4'h0)
    else $error("lanes still driven after frame end");
  pulse_onehot_a: assert property (|cmdPulse |-> $onehot(cmdPulse))
    else $error("more than one command pulse");
  pulse_width_a: assert property (|cmdPulse |=> cmdPulse == '0)
    else $error("command pulse longer than one cycle");
  pulse_frame_a: assert property (|cmdPulse |-> $past(csN, 1) && $past(csN, 2))
    else $error("command pulse before frame end");
  param_hold_a: assert property (csIdle |-> $stable(readParameterByte) && $stable(wrapSettingBits))
    else $error("read parameters changed outside a frame");
  prog_hold_a: assert property (progValid && !progReady |=> progValid && $stable(progWord))
    else $error("program word lost while stalled");
  overrun_keep_a: assert property (progOverrun |=> progOverrun)
    else $error("overrun flag cleared");
  overrun_full_a: assert property ($rose(progOverrun) |-> progValid)
    else $error("overrun with empty buffer");
endmodule // sfif_framer_chk

bind sfif_framer sfif_framer_chk u_chk (.clk(clk), .rst(rst), .csN(csN), .ioOe(ioOe), .cmdPulse(cmdPulse),
  .readParameterByte(readParameterByte), .wrapSettingBits(wrapSettingBits), .progValid(progValid),
  .progReady(progReady), .progWord(progWord), .progOverrun(progOverrun));

// [dv/sfif_framer_tb_top.sv]
// Self-checking bench for the framer; a host model drives the link.
// Assumes the host model and the bound checker are compiled before it.
`timescale 1ns/100ps
`define CHK(g, e, m) begin cmp_count++; if ((g) !== (e)) begin n_fail++; $display("BAD %0t %s", $time, m); end end
module sfif_framer_tb_top import sfif_pkg::*;;
  localparam logic [15:0] PART_TB = 16'h71E4; // Arbitrary value
  logic clk, rst, progReady, csN, sclk, progValid, progOverrun;
  logic [3:0] ioIn, ioOut, ioOe, q;
  logic [7:0] st [3];
  logic [7:0] arrayReadData, readParameterByte, continuousReadModeByte;
  logic [23:0] arrayReadAddr;
  logic [15:0] statusWriteData;
  logic [2:0] wrapSettingBits;
  logic [1:0] securitySelect;
  sfif_cmd_type cmdPulse, lastPulse;
  sfif_prog_type progWord;
  int n_fail = 0;
  int cmp_count = 0;
  logic [7:0] ops [8] = '{8'h06, 8'h50, 8'h04, 8'h75, 8'h7A, 8'hB9, 8'hC7, 8'h60};
  logic [11:0] pul [8] = '{12'h800, 12'h400, 12'h200, 12'h100, 12'h080, 12'h040, 12'h020, 12'h020};
  logic [7:0] rdOps [3] = '{8'h05, 8'h35, 8'h15};
  logic [7:0] wrOps [3] = '{8'h01, 8'h31, 8'h11};
  logic [7:0] wrapExp [3] = '{8'h06, 8'h07, 8'h00};
  logic [7:0] jedExp [4] = '{8'h3D, PART_TB[15:8], PART_TB[7:0], 8'h3D};

  // Array content is a simple function of the address
  assign arrayReadData = arrayReadAddr[7:0] ^ 8'h3C;

  sfif_host_model host (.csN(csN), .sclk(sclk), .ioIn(ioIn), .ioOut(ioOut), .ioOe(ioOe));
  sfif_framer #(.MAKER_ID(8'h3D), .PART_ID(PART_TB)) DUT (.clk(clk), .rst(rst), .csN(csN), .sclk(sclk),
    .ioIn(ioIn), .ioOut(ioOut), .ioOe(ioOe), .statusByteOne(st[0]), .statusByteTwo(st[1]),
    .statusByteThree(st[2]), .arrayReadData(arrayReadData), .arrayReadAddr(arrayReadAddr),
    .cmdPulse(cmdPulse), .statusWriteData(statusWriteData), .readParameterByte(readParameterByte),
    .continuousReadModeByte(continuousReadModeByte), .wrapSettingBits(wrapSettingBits),
    .securitySelect(securitySelect), .progValid(progValid), .progReady(progReady),
    .progWord(progWord), .progOverrun(progOverrun));

  // ----
  // Clock and tasks
  // ----
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Pulses are one cycle wide, so they are caught here and checked later
  always @(posedge clk) begin
    if (|cmdPulse) lastPulse <= cmdPulse;
  end

  task automatic final_report();
    if (n_fail == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic tx(input logic [7:0] d);
    host.nib(d[7:4], q);
    host.nib(d[3:0], q);
  endtask
  task automatic expect_rd(input logic [7:0] e, input string m);
    logic [3:0] hi, lo;
    host.nib(4'h0, hi);
    host.nib(4'hF, lo);
    `CHK({hi, lo}, e, m)
    `CHK(ioOe, 4'hF, "lanes not driven")
  endtask
  task automatic skip(input int n);
    repeat (n) host.nib(4'h0, q);
  endtask
  task automatic frame(input logic [7:0] op, input logic [23:0] a, input bit hasAddr);
    host.begin_frame();
    tx(op);
    if (hasAddr) begin
      tx(a[23:16]);
      tx(a[15:8]);
      tx(a[7:0]);
    end
  endtask
  task automatic close(input sfif_cmd_type e, input string m);
    host.end_frame();
    `CHK(lastPulse, e, m)
    lastPulse = '0;
  endtask
  task automatic pop(input sfif_prog_type e, input bit chk);
    int k;
    k = 0;
    while (progValid !== 1'b1 && k < 50) begin
      @(posedge clk);
      #1;
      k++;
    end
    if (k == 50) begin
      n_fail++;
      final_report();
    end
    if (chk) `CHK(progWord, e, "program word")
    @(posedge clk);
    progReady <= 1'b1;
    @(posedge clk);
    progReady <= 1'b0;
    #1;
  endtask

  // ----
  // Main sequence
  // ----
  initial begin
    rst = 1'b1;
    progReady = 1'b0;
    lastPulse = '0;
    st[0] = 8'h9C;
    st[1] = 8'h4B;
    st[2] = 8'hE1;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
    `CHK({readParameterByte, wrapSettingBits, progValid, ioOe}, {8'h40, 3'h7, 1'b0, 4'h0}, "reset values")
    foreach (ops[i]) begin
      frame(ops[i], 24'h0, 1'b0);
      close(pul[i], "single-byte command pulse");
    end
    for (int i = 0; i < 3; i++) begin
      frame(rdOps[i], 24'h0, 1'b0);
      repeat (3) expect_rd(st[i], "status byte repeat");
      close('0, "pulse after status read");
      frame(wrOps[i], 24'h0, 1'b0);
      tx(8'h5A + i[7:0]);
      close(12'h008 >> i, "status write pulse");
      `CHK(statusWriteData[7:0], 8'h5A + i[7:0], "status write byte")
    end
    frame(8'h01, 24'h0, 1'b0);
    tx(8'hC3);
    tx(8'h96);
    close(12'h001, "status pair pulse");
    `CHK(statusWriteData, 16'h96C3, "status pair data")
    frame(8'hAB, 24'h0, 1'b0);
    skip(6);
    repeat (2) expect_rd(PART_TB[7:0], "part id repeat");
    close(12'h010, "release pulse");
    frame(8'h9F, 24'h0, 1'b0);
    foreach (jedExp[i]) expect_rd(jedExp[i], "jedec id repeat");
    close('0, "pulse after jedec id");
    frame(8'h90, 24'h0, 1'b0);
    skip(6);
    for (int i = 0; i < 4; i++) expect_rd(i[0] ? PART_TB[7:0] : 8'h3D, "maker id repeat");
    close('0, "pulse after maker id");
    frame(8'hEB, 24'h000310, 1'b1);
    tx(8'hA5);
    skip(4);
    expect_rd(8'h10 ^ 8'h3C, "quad io read");
    `CHK(continuousReadModeByte, 8'hA5, "mode byte")
    close('0, "pulse after quad read");
    frame(8'hE7, 24'h000320, 1'b1);
    tx(8'h5A);
    skip(2);
    expect_rd(8'h20 ^ 8'h3C, "word read");
    close('0, "pulse after word read");
    frame(8'hE3, 24'h001030, 1'b1);
    tx(8'h3C);
    expect_rd(8'h30 ^ 8'h3C, "octal word read");
    `CHK(continuousReadModeByte, 8'h3C, "octal mode byte")
    `CHK(securitySelect, 2'h1, "security select one")
    close('0, "pulse after octal read");
    frame(8'hC0, 24'h0, 1'b0);
    tx(8'h20);
    close('0, "pulse after parameter set");
    `CHK(readParameterByte, 8'h20, "read parameter byte")
    frame(8'h0B, 24'h002005, 1'b1);
    skip(2);
    expect_rd(8'h05 ^ 8'h3C, "fast read byte");
    expect_rd(8'h06 ^ 8'h3C, "fast read next");
    `CHK(securitySelect, 2'h2, "security select")
    close('0, "pulse after fast read");
    frame(8'h0C, 24'h000106, 1'b1);
    skip(2);
    foreach (wrapExp[i]) expect_rd(wrapExp[i] ^ 8'h3C, "wrapped read");
    close('0, "pulse after wrapped read");
    frame(8'h77, 24'h0, 1'b0);
    for (int i = 0; i < 8; i++) host.nib((i == 6) ? 4'hA : 4'hF, q);
    close('0, "pulse after wrap set");
    `CHK(wrapSettingBits, 3'h2, "wrap setting bits")
    frame(8'h02, 24'h0001FE, 1'b1);
    tx(8'h11);
    tx(8'h22);
    tx(8'h33);
    close('0, "pulse after program");
    pop({24'h0001FE, 8'h11}, 1'b1);
    pop({24'h0001FF, 8'h22}, 1'b1);
    pop({24'h000100, 8'h33}, 1'b1);
    frame(8'h02, 24'h000000, 1'b1);
    for (int i = 0; i < 12; i++) tx(i[7:0]);
    close('0, "pulse after long program");
    `CHK(progOverrun, 1'b1, "overrun flag")
    pop({24'h000000, 8'h00}, 1'b1);
    for (int i = 0; i < 12 && progValid === 1'b1; i++) pop('0, 1'b0);
    `CHK(progValid, 1'b0, "buffer drained")
    final_report();
  end
endmodule // sfif_framer_tb_top

// [dv/sfif_host_model.sv]
// Host controller model: drives chip select, serial clock and the four lanes.
// Assumes the framer finds link edges on its own clock; link period is 125 ns.
`timescale 1ns/100ps
module sfif_host_model (
  output logic csN,
  output logic sclk,
  output logic [3:0] ioIn,
  input wire logic [3:0] ioOut,
  input wire logic [3:0] ioOe
);
  // ----
  // Link tasks
  // ----
  initial begin
    csN = 1'b1;
    sclk = 1'b0;
    ioIn = 4'h0;
  end
  // Odd offset keeps the link out of phase with the system clock
  task automatic begin_frame();
    #7.3 csN <= 1'b0;
    #62.5;
  endtask
  // Lanes turn to noise mid high phase, so only the rising edge sees valid data
  task automatic nib(input logic [3:0] d, output logic [3:0] q);
    ioIn <= d;
    #62.5 sclk <= 1'b1;
    q = (ioOe === 4'hF) ? ioOut : ~ioOut;
    #31.2 ioIn <= ~d;
    #31.3 sclk <= 1'b0;
  endtask
  task automatic end_frame();
    #62.5 csN <= 1'b1;
    ioIn <= ~ioIn;
    #300;
  endtask
endmodule // sfif_host_model

// [rtl/sfif_fifo.sv]
// Flip-flop FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/100ps
module sfif_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr, rdPtr, next_wrPtr, next_rdPtr;
  logic [AW:0] count, next_count;
  logic push, pop;

  assign inReady = (count != DEPTH[AW:0]);
  assign outValid = (count != '0);
  assign outData = mem[rdPtr];
  assign push = inValid & inReady;
  assign pop = outValid & outReady;

  always_comb begin
    next_wrPtr = push ? AW'(wrPtr + 1'b1) : wrPtr;
    next_rdPtr = pop ? AW'(rdPtr + 1'b1) : rdPtr;
    next_count = AW'(0) + count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else begin
      wrPtr <= next_wrPtr;
      rdPtr <= next_rdPtr;
      count <= next_count;
    end
    if (push) begin
      mem[wrPtr] <= inData;
    end
  end
endmodule // sfif_fifo

// [rtl/sfif_framer.sv]
// Device-side instruction framer for a serial flash in four-wire command mode.
// Assumes the host drives chip select, serial clock and nibbles asynchronously;
// the array, status bytes and program sink sit on clk.
`timescale 1ns/100ps
module sfif_framer import sfif_pkg::*; #(
  parameter logic [7:0] MAKER_ID = 8'hA5,  // Arbitrary value
  parameter logic [15:0] PART_ID = 16'h5A3C  // Arbitrary value
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic csN,
  input wire logic sclk,
  input wire logic [3:0] ioIn,
  output logic [3:0] ioOut,
  output logic [3:0] ioOe,
  input wire logic [7:0] statusByteOne,
  input wire logic [7:0] statusByteTwo,
  input wire logic [7:0] statusByteThree,
  input wire logic [7:0] arrayReadData,
  output logic [23:0] arrayReadAddr,
  output sfif_cmd_type cmdPulse,
  output logic [15:0] statusWriteData,
  output logic [7:0] readParameterByte,
  output logic [7:0] continuousReadModeByte,
  output logic [2:0] wrapSettingBits,
  output logic [1:0] securitySelect,
  output logic progValid,
  input wire logic progReady,
  output sfif_prog_type progWord,
  output logic progOverrun
);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [5:0] pinMeta, pinSync;
  logic sclkPrev, csPrevN;
  always_ff @(posedge clk) begin
    if (rst) begin
      pinMeta <= 6'h3F;
      pinSync <= 6'h3F;
      sclkPrev <= 1'b1;
      csPrevN <= 1'b1;
    end else begin
      pinMeta <= {csN, sclk, ioIn};
      pinSync <= pinMeta;
      sclkPrev <= pinSync[4];
      csPrevN <= pinSync[5];
    end
  end

  logic csLow, sclkRise, sclkFall, csStart, csEnd;
  logic [3:0] ioNib;
  assign csLow = ~pinSync[5];
  assign ioNib = pinSync[3:0];
  assign sclkRise = csLow & pinSync[4] & ~sclkPrev;
  assign sclkFall = csLow & ~pinSync[4] & sclkPrev;
  assign csStart = csLow & csPrevN;
  assign csEnd = ~csLow & ~csPrevN;

  // ----------------------------------------
  // Frame state
  // ----------------------------------------
  sfif_phase_type phase, next_phase;
  logic [5:0] clkIdx, next_clkIdx;
  logic [4:0] waitCnt, next_waitCnt;
  logic nibOdd, next_nibOdd;
  logic [3:0] hiNib, next_hiNib;
  logic [7:0] opcode, next_opcode;
  logic [23:0] addr, next_addr;
  logic [1:0] byteCnt, next_byteCnt;
  logic [7:0] outByte, next_outByte;
  logic [1:0] idSeq, next_idSeq;
  logic [3:0] next_ioOut, next_ioOe;
  logic [23:0] next_arrayReadAddr;
  sfif_cmd_type next_cmdPulse;
  logic [15:0] next_statusWriteData;
  logic [7:0] next_readParameterByte, next_continuousReadModeByte;
  logic [2:0] next_wrapSettingBits;
  logic [1:0] next_securitySelect;
  logic pushValid, next_pushValid, pushReady, next_progOverrun;
  sfif_prog_type pushWord, next_pushWord;
  logic [7:0] inByte, wrapMask, srcByte;
  logic [4:0] dummyNibbles;

  assign inByte = {hiNib, ioNib};
  assign dummyNibbles = {1'b0, readParameterByte[7:4]};
  assign wrapMask = 8'((WRAP_BASE_BYTES << readParameterByte[1:0]) - 1'b1);

  // Byte to send next in the output phase
  always_comb begin
    unique case (opcode)
      OP_RDSR1: srcByte = statusByteOne;
      OP_RDSR2: srcByte = statusByteTwo;
      OP_RDSR3: srcByte = statusByteThree;
      OP_RELPD: srcByte = PART_ID[7:0];
      OP_MFID: srcByte = idSeq[0] ? PART_ID[7:0] : MAKER_ID;
      OP_JEDEC: srcByte = (idSeq == 2'd0) ? MAKER_ID : (idSeq == 2'd1) ? PART_ID[15:8] : PART_ID[7:0];
      default: srcByte = arrayReadData;
    endcase
  end

  always_comb begin
    next_phase = phase;
    next_clkIdx = clkIdx;
    next_waitCnt = waitCnt;
    next_nibOdd = nibOdd;
    next_hiNib = hiNib;
    next_opcode = opcode;
    next_addr = addr;
    next_byteCnt = byteCnt;
    next_outByte = outByte;
    next_idSeq = idSeq;
    next_ioOut = ioOut;
    next_ioOe = ioOe;
    next_arrayReadAddr = arrayReadAddr;
    next_cmdPulse = '0;
    next_statusWriteData = statusWriteData;
    next_readParameterByte = readParameterByte;
    next_continuousReadModeByte = continuousReadModeByte;
    next_wrapSettingBits = wrapSettingBits;
    next_securitySelect = securitySelect;
    next_pushValid = pushValid & ~pushReady;
    next_pushWord = pushWord;
    next_progOverrun = progOverrun;

    if (csStart) begin
      next_phase = PH_OPCODE;
      next_clkIdx = '0;
      next_nibOdd = 1'b0;
      next_byteCnt = '0;
      next_idSeq = '0;
    end else if (csEnd && phase != PH_IDLE) begin
      next_phase = PH_IDLE;
      next_ioOe = 4'h0;
      if (phase == PH_SKIP && clkIdx == CLK_OPCODE_END) begin
        next_cmdPulse.writeEnableSet = (opcode == OP_WREN);
        next_cmdPulse.volatileWriteEnable = (opcode == OP_VWREN);
        next_cmdPulse.writeEnableClear = (opcode == OP_WRDI);
        next_cmdPulse.suspend = (opcode == OP_SUSPEND);
        next_cmdPulse.resume = (opcode == OP_RESUME);
        next_cmdPulse.powerDown = (opcode == OP_PWRDOWN);
        next_cmdPulse.chipErase = (opcode == OP_CERASE1) || (opcode == OP_CERASE2);
      end
      if (phase == PH_DOUT && opcode == OP_RELPD) begin
        next_cmdPulse.releasePowerDown = 1'b1;
      end
      if (phase == PH_DIN && byteCnt == 2'd1) begin
        next_cmdPulse.statusWriteOne = (opcode == OP_WRSR1);
        next_cmdPulse.statusWriteTwo = (opcode == OP_WRSR2);
        next_cmdPulse.statusWriteThree = (opcode == OP_WRSR3);
      end
      if (phase == PH_DIN && byteCnt == 2'd2) begin
        next_cmdPulse.statusWritePair = (opcode == OP_WRSR1);
      end
    end else if (sclkRise) begin
      next_clkIdx = (clkIdx == CLK_MAX) ? clkIdx : 6'(clkIdx + 1'b1);
      next_nibOdd = ~nibOdd;
      if (!nibOdd) begin
        next_hiNib = ioNib;
      end
      unique case (phase)
        PH_OPCODE: if (nibOdd) begin
          next_opcode = inByte;
          next_phase = PH_SKIP;
          next_securitySelect = '0;
          unique case (inByte)
            OP_RDSR1, OP_RDSR2, OP_RDSR3, OP_JEDEC: next_phase = PH_DOUT;
            OP_RELPD, OP_MFID: begin
              next_phase = PH_WAIT;
              next_waitCnt = ID_DUMMY_NIBBLES;
            end
            OP_BURSTWRAP: begin
              next_phase = PH_WAIT;
              next_waitCnt = WRAP_CMD_NIBBLES;
            end
            OP_WRSR1, OP_WRSR2, OP_WRSR3, OP_SETPARAM: next_phase = PH_DIN;
            OP_PROG, OP_FREAD, OP_WRAPREAD, OP_QIOREAD, OP_WORDREAD, OP_OCTREAD: begin
              next_phase = PH_ADDR;
              next_waitCnt = ADDR_NIBBLES;
            end
            default: next_phase = PH_SKIP;
          endcase
        end
        PH_ADDR: begin
          next_addr = {addr[19:0], ioNib};
          next_waitCnt = 5'(waitCnt - 1'b1);
          if (waitCnt == 5'd1) begin
            next_arrayReadAddr = {addr[19:0], ioNib};
            next_securitySelect = (addr[19:12] != SEC_HIGH) ? 2'd0 :
              (addr[11:4] == SEC_MID1) ? 2'd1 :
              (addr[11:4] == SEC_MID2) ? 2'd2 :
              (addr[11:4] == SEC_MID3) ? 2'd3 : 2'd0;
            unique case (opcode)
              OP_PROG: next_phase = PH_DIN;
              OP_FREAD, OP_WRAPREAD: begin
                next_phase = (dummyNibbles == '0) ? PH_DOUT : PH_WAIT;
                next_waitCnt = dummyNibbles;
              end
              OP_QIOREAD: begin
                next_phase = PH_WAIT;
                next_waitCnt = 5'(MODE_NIBBLES + dummyNibbles);
              end
              OP_WORDREAD: begin
                next_phase = PH_WAIT;
                next_waitCnt = 5'(MODE_NIBBLES + WORD_DUMMY);
              end
              default: begin
                next_phase = PH_WAIT;
                next_waitCnt = MODE_NIBBLES;
              end
            endcase
          end
        end
        PH_WAIT: begin
          next_waitCnt = 5'(waitCnt - 1'b1);
          if (clkIdx == 6'd9 && opcode inside {OP_QIOREAD, OP_WORDREAD, OP_OCTREAD}) begin
            next_continuousReadModeByte = inByte;
          end
          if (clkIdx == CLK_WRAP_NIBBLE && opcode == OP_BURSTWRAP) begin
            next_wrapSettingBits = ioNib[2:0];
          end
          if (waitCnt == 5'd1) begin
            next_phase = (opcode == OP_BURSTWRAP) ? PH_SKIP : PH_DOUT;
          end
        end
        PH_DIN: if (nibOdd) begin
          next_byteCnt = (byteCnt == 2'd3) ? byteCnt : 2'(byteCnt + 1'b1);
          unique case (opcode)
            OP_SETPARAM: next_readParameterByte = inByte;
            OP_PROG: begin
              if (pushValid && !pushReady) begin
                next_progOverrun = 1'b1;
              end
              next_pushValid = 1'b1;
              next_pushWord = '{addr: addr, data: inByte};
              next_addr = {addr[23:8], 8'(addr[7:0] + 1'b1)};
            end
            default: begin
              if (byteCnt == 2'd0) begin
                next_statusWriteData = {8'h00, inByte};
              end else if (byteCnt == 2'd1) begin
                next_statusWriteData = {inByte, statusWriteData[7:0]};
              end
            end
          endcase
        end
        default: ;
      endcase
      if (phase == PH_WAIT && waitCnt == 5'd1) begin
        next_nibOdd = 1'b0;
      end else if (phase == PH_ADDR && waitCnt == 5'd1 && dummyNibbles == '0) begin
        next_nibOdd = 1'b0;
      end
    end else if (sclkFall && phase == PH_DOUT) begin
      next_ioOe = 4'hF;
      if (!nibOdd) begin
        next_outByte = srcByte;
        next_ioOut = srcByte[7:4];
        next_idSeq = (idSeq == 2'd2 || (opcode == OP_MFID && idSeq[0])) ? 2'd0 : 2'(idSeq + 1'b1);
        if (opcode == OP_WRAPREAD) begin
          next_arrayReadAddr = {arrayReadAddr[23:8],
            (arrayReadAddr[7:0] & ~wrapMask) | (8'(arrayReadAddr[7:0] + 1'b1) & wrapMask)};
        end else begin
          next_arrayReadAddr = 24'(arrayReadAddr + 1'b1);
        end
      end else begin
        next_ioOut = outByte[3:0];
      end
    end
    if (opcode == OP_PROG && phase == PH_DIN && !nibOdd && csEnd && pushValid && !pushReady) begin
      next_progOverrun = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      phase <= PH_IDLE;
      clkIdx <= '0;
      waitCnt <= '0;
      nibOdd <= 1'b0;
      hiNib <= 4'h0;
      opcode <= 8'h00;
      addr <= 24'h000000;
      byteCnt <= '0;
      outByte <= 8'h00;
      idSeq <= '0;
      ioOut <= 4'h0;
      ioOe <= 4'h0;
      arrayReadAddr <= 24'h000000;
      cmdPulse <= '0;
      statusWriteData <= 16'h0000;
      readParameterByte <= READ_PARAM_RESET;
      continuousReadModeByte <= 8'h00;
      wrapSettingBits <= WRAP_SETTING_RESET;
      securitySelect <= '0;
      pushValid <= 1'b0;
      pushWord <= '0;
      progOverrun <= 1'b0;
    end else begin
      phase <= next_phase;
      clkIdx <= next_clkIdx;
      waitCnt <= next_waitCnt;
      nibOdd <= next_nibOdd;
      hiNib <= next_hiNib;
      opcode <= next_opcode;
      addr <= next_addr;
      byteCnt <= next_byteCnt;
      outByte <= next_outByte;
      idSeq <= next_idSeq;
      ioOut <= next_ioOut;
      ioOe <= next_ioOe;
      arrayReadAddr <= next_arrayReadAddr;
      cmdPulse <= next_cmdPulse;
      statusWriteData <= next_statusWriteData;
      readParameterByte <= next_readParameterByte;
      continuousReadModeByte <= next_continuousReadModeByte;
      wrapSettingBits <= next_wrapSettingBits;
      securitySelect <= next_securitySelect;
      pushValid <= next_pushValid;
      pushWord <= next_pushWord;
      progOverrun <= next_progOverrun;
    end
  end

  // ----------------------------------------
  // Program data buffer
  // ----------------------------------------
  // A full buffer holds the byte back; a held byte still waiting when another arrives is lost
  // and flagged, since the host clock cannot be stalled.
  sfif_fifo #(
    .WIDTH($bits(sfif_prog_type)),
    .DEPTH(FIFO_DEPTH)
  ) progFifo (
    .clk(clk),
    .rst(rst),
    .inValid(pushValid),
    .inReady(pushReady),
    .inData(pushWord),
    .outValid(progValid),
    .outReady(progReady),
    .outData(progWord)
  );

endmodule // sfif_framer

// [rtl/sfif_pkg.sv]
// Package for the four-wire serial flash instruction framer.
// Assumes a single 100 MHz system clock domain on the device side.
package sfif_pkg;

  // ----------------------------------------
  // Opcodes
  // ----------------------------------------
  localparam logic [7:0] OP_WREN = 8'h06;
  localparam logic [7:0] OP_VWREN = 8'h50;
  localparam logic [7:0] OP_WRDI = 8'h04;
  localparam logic [7:0] OP_RDSR1 = 8'h05;
  localparam logic [7:0] OP_RDSR2 = 8'h35;
  localparam logic [7:0] OP_RDSR3 = 8'h15;
  localparam logic [7:0] OP_WRSR1 = 8'h01;
  localparam logic [7:0] OP_WRSR2 = 8'h31;
  localparam logic [7:0] OP_WRSR3 = 8'h11;
  localparam logic [7:0] OP_CERASE1 = 8'hC7;
  localparam logic [7:0] OP_CERASE2 = 8'h60;
  localparam logic [7:0] OP_SUSPEND = 8'h75;
  localparam logic [7:0] OP_RESUME = 8'h7A;
  localparam logic [7:0] OP_PWRDOWN = 8'hB9;
  localparam logic [7:0] OP_SETPARAM = 8'hC0;
  localparam logic [7:0] OP_RELPD = 8'hAB;
  localparam logic [7:0] OP_MFID = 8'h90;
  localparam logic [7:0] OP_JEDEC = 8'h9F;
  localparam logic [7:0] OP_PROG = 8'h02;
  localparam logic [7:0] OP_FREAD = 8'h0B;
  localparam logic [7:0] OP_WRAPREAD = 8'h0C;
  localparam logic [7:0] OP_QIOREAD = 8'hEB;
  localparam logic [7:0] OP_WORDREAD = 8'hE7;
  localparam logic [7:0] OP_OCTREAD = 8'hE3;
  localparam logic [7:0] OP_BURSTWRAP = 8'h77;

  // ----------------------------------------
  // Frame positions, in nibble clocks
  // ----------------------------------------
  localparam logic [5:0] CLK_OPCODE_END = 6'd2;
  localparam logic [4:0] ADDR_NIBBLES = 5'd6;
  localparam logic [4:0] MODE_NIBBLES = 5'd2;
  localparam logic [4:0] WORD_DUMMY = 5'd2;
  localparam logic [4:0] ID_DUMMY_NIBBLES = 5'd6;
  localparam logic [4:0] WRAP_CMD_NIBBLES = 5'd8;
  localparam logic [5:0] CLK_WRAP_NIBBLE = 6'd8;
  localparam logic [5:0] CLK_MAX = 6'h3F;

  // ----------------------------------------
  // Security register map, reset values, wrap base size and buffer depth
  // ----------------------------------------
  localparam logic [7:0] SEC_HIGH = 8'h00;
  localparam logic [7:0] SEC_MID1 = 8'h10;
  localparam logic [7:0] SEC_MID2 = 8'h20;
  localparam logic [7:0] SEC_MID3 = 8'h30;
  localparam logic [7:0] READ_PARAM_RESET = 8'h40;
  localparam logic [2:0] WRAP_SETTING_RESET = 3'h7;
  localparam logic [7:0] WRAP_BASE_BYTES = 8'h08;
  localparam int FIFO_DEPTH = 8;

  typedef enum logic [2:0] {
    PH_IDLE, PH_OPCODE, PH_ADDR, PH_WAIT, PH_DIN, PH_DOUT, PH_SKIP
  } sfif_phase_type;

  typedef struct packed {
    logic [23:0] addr;
    logic [7:0] data;
  } sfif_prog_type;

  typedef struct packed {
    logic writeEnableSet;
    logic volatileWriteEnable;
    logic writeEnableClear;
    logic suspend;
    logic resume;
    logic powerDown;
    logic chipErase;
    logic releasePowerDown;
    logic statusWriteOne;
    logic statusWriteTwo;
    logic statusWriteThree;
    logic statusWritePair;
  } sfif_cmd_type;

endpackage
